/* File: test/controller_model.sv */
// Bus controller model that feeds command strings to the parser byte by byte
`timescale 1ns/1ps
module controller_model (
   input wire logic i_clk,
   input wire logic i_rx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_stuck
);
   initial begin
      o_rx_valid = 1'b0;
      o_rx_byte = 8'h00;
      o_stuck = 1'b0;
   end

   // Bytes go out in string order; values keep their leading space
   // and whichever quote character the caller chose
   task automatic send(input string s);
      int n;
      for (int i = 0; i < s.len(); i++) begin
         @(negedge i_clk);
         o_rx_valid = 1'b1;
         o_rx_byte = s[i];
         n = 0;
         // Ready is a register, settled at the falling edge
         while (i_rx_ready !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
         end
         if (n >= 200) begin
            o_stuck = 1'b1;
         end
         @(posedge i_clk);
      end
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      // Released line shows no stale byte
      o_rx_byte = ~o_rx_byte;
   endtask : send
endmodule : controller_model

/* File: test/gpib_command_parser_tb.sv */
// Self-checking bench for the command parser
`timescale 1ns/1ps
`include "gpib_parser_cfg.svh"
`define CHK(nm, ex, gt) begin \
   checks_done++; \
   if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("mismatch %s exp %h got %h", nm, ex, gt); \
   end \
end
module gpib_command_parser_tb;
   import gpib_parser_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_rx_valid;
   logic [7:0] i_rx_byte;
   logic o_rx_ready;
   logic o_cmd_valid;
   cmd_t o_cmd;
   logic i_cmd_accept = 1'b0;
   logic i_result_ready = 1'b0;
   logic i_result_is_string = 1'b0;
   logic i_result_read = 1'b0;
   logic o_result_quoted;
   logic o_message_available_flag;
   logic o_err_valid;
   logic [15:0] o_err_code;
   logic o_freq_settling;
   logic stuck;
   int mismatches = 0;
   int checks_done = 0;
   int err_count = 0;
   logic [15:0] err_last = 16'h0000;
   // Short settle window so the countdown fits in a short run
   localparam int SETTLE_SIM = 20;

   always #5 i_clk = ~i_clk;

   gpib_command_parser #(.CMD_DEPTH(4), .SETTLE_CYCLES(SETTLE_SIM))
      i_gpib_command_parser (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_rx_valid(i_rx_valid),
      .i_rx_byte(i_rx_byte), .o_rx_ready(o_rx_ready),
      .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .i_cmd_accept(i_cmd_accept),
      .i_result_ready(i_result_ready),
      .i_result_is_string(i_result_is_string),
      .i_result_read(i_result_read), .o_result_quoted(o_result_quoted),
      .o_message_available_flag(o_message_available_flag),
      .o_err_valid(o_err_valid), .o_err_code(o_err_code),
      .o_freq_settling(o_freq_settling));

   controller_model i_controller_model (
      .i_clk(i_clk), .i_rx_ready(o_rx_ready), .o_rx_valid(i_rx_valid),
      .o_rx_byte(i_rx_byte), .o_stuck(stuck));

   // Error pulses last one cycle; logged mid-cycle while they stand
   always @(negedge i_clk) begin
      if (o_err_valid === 1'b1) begin
         err_count++;
         err_last = o_err_code;
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // Waits for a command, takes it with a one-cycle accept
   task automatic get_cmd(output cmd_t c);
      int n;
      n = 0;
      while (o_cmd_valid !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 300) begin
            mismatches++;
            $display("mismatch cmd wait exp 1 got 0");
            print_verdict();
         end
      end
      c = o_cmd;
      i_cmd_accept = 1'b1;
      @(negedge i_clk);
      i_cmd_accept = 1'b0;
      `CHK("cmd drop", 1'b0, o_cmd_valid)
   endtask : get_cmd

   task automatic result_cycle(input logic str);
      i_result_ready = 1'b1;
      i_result_is_string = str;
      @(negedge i_clk);
      i_result_ready = 1'b0;
      `CHK("flag set", 1'b1, o_message_available_flag)
      `CHK("format", str, o_result_quoted)
      i_result_read = 1'b1;
      @(negedge i_clk);
      i_result_read = 1'b0;
      `CHK("flag clr", 1'b0, o_message_available_flag)
   endtask : result_cycle

   task automatic t_reset();
      repeat (3) @(negedge i_clk);
      `CHK("rst valid", 1'b0, o_cmd_valid)
      `CHK("rst flag", 1'b0, o_message_available_flag)
      i_rstn = 1'b1;
      @(negedge i_clk);
      `CHK("rst ready", 1'b1, o_rx_ready)
   endtask : t_reset

   task automatic t_query();
      cmd_t c;
      i_controller_model.send("a?\n");
      get_cmd(c);
      `CHK("query", 1'b1, c.query)
      `CHK("q key", 32'h41000000, c.path[0].chars)
      `CHK("q level", 2'd0, c.level)
      `CHK("q noval", 1'b0, c.has_value)
      result_cycle(1'b1);
   endtask : t_query

   task automatic t_forms();
      cmd_t a;
      cmd_t b;
      i_controller_model.send("AFGENERATOR1:destination 'audio out'\n");
      get_cmd(a);
      i_controller_model.send("afg1:DEST \"AUDIO OUT\"\n");
      get_cmd(b);
      `CHK("forms", a, b)
      `CHK("key0", 32'h41464700, a.path[0].chars)
      `CHK("digit", 4'h1, b.path[0].digit)
      `CHK("key1", 32'h44455354, b.path[1].chars)
      `CHK("value", 64'h415544494f204f55, a.value)
      `CHK("quoted", 1'b1, b.quoted & a.quoted)
      `CHK("val len", 4'd8, a.value_len)
      `CHK("has val", 1'b1, b.has_value)
      `CHK("level", 2'd1, a.level)
   endtask : t_forms

   task automatic t_semicolon();
      cmd_t c;
      i_controller_model.send("DISP AFAN;AFAN:INP 'AM';FILT1 'X'\n");
      `CHK("held", 1'b1, o_cmd_valid)
      get_cmd(c);
      `CHK("first", 32'h44495350, c.path[0].chars)
      get_cmd(c);
      `CHK("second", 32'h494e5000, c.path[1].chars)
      get_cmd(c);
      `CHK("same top", 32'h4146414e, c.path[0].chars)
      `CHK("same lvl", 2'd1, c.level)
      `CHK("third", 32'h46494c54, c.path[1].chars)
      `CHK("third dig", 1'b1, c.path[1].has_digit)
   endtask : t_semicolon

   task automatic t_top_freq();
      cmd_t c;
      int cnt;
      cnt = 0;
      i_controller_model.send("RFAN:FREQ 850MHZ;:AFAN:INP 'FM'\n");
      get_cmd(c);
      `CHK("freq key", `KEY_FREQ, c.path[1].chars)
      // Window opened at the accept edge, so sampling starts right now
      for (int i = 0; i < 40; i++) begin
         if (o_freq_settling === 1'b1)
            cnt++;
         @(negedge i_clk);
      end
      `CHK("settle", SETTLE_SIM, cnt)
      get_cmd(c);
      `CHK("top key", 32'h4146414e, c.path[0].chars)
      `CHK("top lvl", 2'd1, c.level)
   endtask : t_top_freq

   task automatic t_syntax();
      int e;
      e = err_count;
      i_controller_model.send(":A:B:C:D\n");
      repeat (3) @(negedge i_clk);
      `CHK("syn err", e + 1, err_count)
      `CHK("syn code", `ERR_SYNTAX, err_last)
      repeat (10) @(negedge i_clk);
      `CHK("not sent", 1'b0, o_cmd_valid)
   endtask : t_syntax

   task automatic t_interrupt();
      cmd_t c;
      int e;
      e = err_count;
      i_controller_model.send("Q?\n");
      get_cmd(c);
      i_controller_model.send("*stb?\n");
      repeat (3) @(negedge i_clk);
      `CHK("int err", e + 1, err_count)
      `CHK("int code", 16'hfe66, err_last)
      `CHK("int drop", 1'b0, o_cmd_valid)
      result_cycle(1'b0);
   endtask : t_interrupt

   initial begin
      t_reset();
      t_query();
      t_forms();
      t_semicolon();
      t_top_freq();
      t_syntax();
      t_interrupt();
      `CHK("rx stuck", 1'b0, stuck)
      print_verdict();
   end
endmodule : gpib_command_parser_tb

/* File: verilog/gpib_command_parser.sv */
// Command string parser and in-order dispatcher behind the instrument bus
//
// Notes on behaviour
// - Commands run one at a time, in order.
// - Bytes keep arriving while commands execute.
// - Structure checked before forwarding to hardware.
// - Command done once hardware has taken it.
// - Frequency settles within 150 ms.
// - Long keywords also accept short form.
// - Keywords and quoted values ignore letter case.
// - Bad punctuation reports syntax error -102.
// - Single or double quotes both delimit strings.
// - Colon descends one hierarchy level.
// - Semicolon keeps next command at same level.
// - Semicolon then colon returns to top.
// - Trailing question mark makes a query.
// - Query answers keep the setting's format.
// - Status command during pending query logs -410.
// - Message available flag set when result ready.
`timescale 1ns/1ps
`include "gpib_parser_cfg.svh"
module gpib_command_parser #(
   parameter int CMD_DEPTH = 4,
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   output logic o_rx_ready,
   output logic o_cmd_valid,
   output gpib_parser_pkg::cmd_t o_cmd,
   input wire logic i_cmd_accept,
   input wire logic i_result_ready,
   input wire logic i_result_is_string,
   input wire logic i_result_read,
   output logic o_result_quoted,
   output logic o_message_available_flag,
   output logic o_err_valid,
   output logic [15:0] o_err_code,
   output logic o_freq_settling
);
   import gpib_parser_pkg::*;
   localparam int PW = $clog2(CMD_DEPTH);

   pstate_t st_q, st_d;
   logic [1:0] level_q, level_d;
   key_t [2:0] path_q, path_d;
   logic [31:0] chars_q, chars_d;
   logic [2:0] klen_q, klen_d;
   logic [3:0] digit_q, digit_d;
   logic hasdig_q, hasdig_d, first_q, first_d, query_q, query_d;
   logic hasval_q, hasval_d, quoted_q, quoted_d;
   logic [7:0] delim_q, delim_d;
   logic [63:0] val_q, val_d;
   logic [3:0] vlen_q, vlen_d;
   logic end_cmd, perr, push, err_fire;
   logic [15:0] err_code;
   cmd_t cmd_new;
   cmd_t mem_q [CMD_DEPTH];
   logic [PW-1:0] wr_q, rd_q;
   logic [PW:0] cnt_q;
   xstate_t ex_q;
   logic qpend_q;
   logic [23:0] settle_q;

   wire take = i_rx_valid && o_rx_ready;
   wire [7:0] c = i_rx_byte;
   wire [7:0] cu = fold_case(c);
   wire is_term = (c == `CH_NL) || (c == `CH_SEMI);
   wire is_quote = (c == `CH_SQUOTE) || (c == `CH_DQUOTE);
   wire key_state = (st_q == ST_KEY) || (st_q == ST_SEMI);
   wire key_t cur_key = close_key(chars_q, klen_q, digit_q, hasdig_q);
   wire status_cmd = cmd_new.path[level_q].chars == `KEY_STATUS;
   wire qint = end_cmd && status_cmd && qpend_q;
   wire pop = (ex_q == EX_IDLE) && (cnt_q != '0);
   wire [PW:0] cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   wire sent = (ex_q == EX_SEND) && i_cmd_accept;
   wire freq_cmd = !o_cmd.query && o_cmd.has_value &&
                   o_cmd.path[o_cmd.level].chars == `KEY_FREQ;
   wire [23:0] settle_d = (sent && freq_cmd) ? 24'(SETTLE_CYCLES) :
                          (settle_q != '0) ? settle_q - 24'h000001 : settle_q;

   always_comb begin
      cmd_new.path = path_q;
      if (key_state)
         cmd_new.path[level_q] = cur_key;
      cmd_new.level = level_q;
      cmd_new.query = query_q;
      cmd_new.has_value = hasval_q;
      cmd_new.quoted = quoted_q;
      cmd_new.value = val_q;
      cmd_new.value_len = vlen_q;
   end

   always_comb begin
      st_d = st_q;
      level_d = level_q;
      path_d = path_q;
      chars_d = chars_q;
      klen_d = klen_q;
      digit_d = digit_q;
      hasdig_d = hasdig_q;
      first_d = first_q;
      query_d = query_q;
      hasval_d = hasval_q;
      quoted_d = quoted_q;
      delim_d = delim_q;
      val_d = val_q;
      vlen_d = vlen_q;
      end_cmd = 1'b0;
      perr = 1'b0;
      if (take) begin
         case (st_q)
            ST_KEY, ST_SEMI: begin
               if (st_q == ST_SEMI && c == `CH_COLON) begin
                  level_d = 2'd0;
                  st_d = ST_KEY;
               end else if (c == `CH_COLON) begin
                  if (klen_q == '0 && first_q) begin
                     level_d = 2'd0;
                     first_d = 1'b0;
                  end else if (klen_q == '0 || level_q == `MAX_LEVEL) begin
                     perr = 1'b1;
                  end else begin
                     path_d[level_q] = cur_key;
                     level_d = level_q + 2'd1;
                     chars_d = '0;
                     klen_d = '0;
                     digit_d = '0;
                     hasdig_d = 1'b0;
                     st_d = ST_KEY;
                  end
               end else if (c == `CH_QMARK) begin
                  perr = (klen_q == '0);
                  path_d[level_q] = cur_key;
                  query_d = 1'b1;
                  st_d = ST_QUERY;
               end else if (c == `CH_SPACE) begin
                  if (klen_q != '0) begin
                     path_d[level_q] = cur_key;
                     st_d = ST_VALUE;
                  end
               end else if (is_term) begin
                  if (klen_q != '0)
                     end_cmd = 1'b1;
                  else if (!(c == `CH_NL && first_q))
                     perr = 1'b1;
               end else if ((is_alpha(c) || (c == `CH_STAR && klen_q == '0))
                            && !hasdig_q) begin
                  if (klen_q < 3'(`KEY_CHARS))
                     chars_d[8*(3-int'(klen_q)) +: 8] = cu;
                  if (klen_q <= 3'(`KEY_CHARS))
                     klen_d = klen_q + 3'd1;
                  first_d = 1'b0;
                  st_d = ST_KEY;
               end else if (is_digit(c) && klen_q != '0 && !hasdig_q) begin
                  digit_d = c[3:0];
                  hasdig_d = 1'b1;
               end else begin
                  perr = 1'b1;
               end
            end
            ST_VALUE, ST_QUOTE: begin
               if (st_q == ST_QUOTE && c == delim_q) begin
                  st_d = ST_CLOSED;
               end else if (st_q == ST_VALUE && is_term) begin
                  end_cmd = hasval_q;
                  perr = !hasval_q;
               end else if (c == `CH_NL) begin
                  perr = 1'b1;
               end else if (st_q == ST_VALUE && is_quote && !hasval_q) begin
                  delim_d = c;
                  quoted_d = 1'b1;
                  hasval_d = 1'b1;
                  st_d = ST_QUOTE;
               end else if (st_q == ST_QUOTE || hasval_q || c != `CH_SPACE)
                  begin
                  hasval_d = 1'b1;
                  if (vlen_q < 4'(`VALUE_CHARS)) begin
                     val_d[8*(7-int'(vlen_q)) +: 8] = cu;
                     vlen_d = vlen_q + 4'd1;
                  end
               end
            end
            ST_CLOSED, ST_QUERY: begin
               if (is_term)
                  end_cmd = 1'b1;
               else if (c != `CH_SPACE)
                  perr = 1'b1;
            end
            ST_SKIP: begin
               if (c == `CH_NL) begin
                  st_d = ST_KEY;
                  level_d = 2'd0;
                  first_d = 1'b1;
               end
            end
            default: st_d = ST_KEY;
         endcase
         if (end_cmd || perr) begin
            chars_d = '0;
            klen_d = '0;
            digit_d = '0;
            hasdig_d = 1'b0;
            query_d = 1'b0;
            hasval_d = 1'b0;
            quoted_d = 1'b0;
            val_d = '0;
            vlen_d = '0;
            first_d = (c == `CH_NL);
            st_d = (c == `CH_SEMI && end_cmd) ? ST_SEMI :
                   (c == `CH_NL) ? ST_KEY : ST_SKIP;
            if (c == `CH_NL)
               level_d = 2'd0;
         end
      end
   end

   assign push = end_cmd && !perr && !qint;
   assign err_fire = perr || qint;
   assign err_code = qint ? `ERR_QUERY_INT : `ERR_SYNTAX;

   always_ff @(posedge i_clk) begin
      if (push)
         mem_q[wr_q] <= cmd_new;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st_q <= ST_KEY;
         level_q <= 2'd0;
         path_q <= '0;
         chars_q <= '0;
         klen_q <= '0;
         digit_q <= '0;
         hasdig_q <= 1'b0;
         first_q <= 1'b1;
         query_q <= 1'b0;
         hasval_q <= 1'b0;
         quoted_q <= 1'b0;
         delim_q <= '0;
         val_q <= '0;
         vlen_q <= '0;
      end else begin
         st_q <= st_d;
         level_q <= level_d;
         path_q <= path_d;
         chars_q <= chars_d;
         klen_q <= klen_d;
         digit_q <= digit_d;
         hasdig_q <= hasdig_d;
         first_q <= first_d;
         query_q <= query_d;
         hasval_q <= hasval_d;
         quoted_q <= quoted_d;
         delim_q <= delim_d;
         val_q <= val_d;
         vlen_q <= vlen_d;
      end
   end

   // Queue depth must be a power of two so pointers wrap by themselves
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         o_rx_ready <= 1'b0;
         ex_q <= EX_IDLE;
         o_cmd_valid <= 1'b0;
         o_cmd <= '0;
         qpend_q <= 1'b0;
         o_message_available_flag <= 1'b0;
         o_result_quoted <= 1'b0;
         o_err_valid <= 1'b0;
         o_err_code <= '0;
         settle_q <= '0;
         o_freq_settling <= 1'b0;
      end else begin
         wr_q <= wr_q + PW'(push);
         rd_q <= rd_q + PW'(pop);
         cnt_q <= cnt_d;
         o_rx_ready <= cnt_d < (PW+1)'(CMD_DEPTH);
         if (pop) begin
            o_cmd <= mem_q[rd_q];
            o_cmd_valid <= 1'b1;
            ex_q <= EX_SEND;
         end else if (sent) begin
            o_cmd_valid <= 1'b0;
            ex_q <= EX_IDLE;
         end
         qpend_q <= (sent && o_cmd.query) || (qpend_q && !i_result_read);
         o_message_available_flag <= i_result_ready ||
            (o_message_available_flag && !i_result_read);
         if (i_result_ready)
            o_result_quoted <= i_result_is_string;
         o_err_valid <= err_fire;
         if (err_fire)
            o_err_code <= err_code;
         settle_q <= settle_d;
         o_freq_settling <= settle_d != '0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_HOLD_UNTIL_TAKEN: assert property (o_cmd_valid && !i_cmd_accept
      |=> o_cmd_valid && $stable(o_cmd)) else $error("command changed early");
   AST_DONE_ON_ACCEPT: assert property (o_cmd_valid && i_cmd_accept
      |=> !o_cmd_valid) else $error("command not retired");
   AST_RX_OPEN: assert property (o_cmd_valid && cnt_q == '0
      |=> o_rx_ready) else $error("reception stalled during execution");
   AST_QUOTE_NL: assert property (take && st_q == ST_QUOTE && c == `CH_NL
      |=> o_err_valid && o_err_code == `ERR_SYNTAX) else $error("no -102");
   AST_QINT: assert property (take && qint
      |=> o_err_valid && o_err_code == `ERR_QUERY_INT && cnt_q == $past(cnt_q)
          - (PW+1)'($past(pop))) else $error("no -410");
   AST_MAV: assert property (i_result_ready
      |=> o_message_available_flag) else $error("flag not set");
   AST_TOP: assert property (take && st_q == ST_SEMI && c == `CH_COLON
      |=> level_q == 2'd0) else $error("not at top level");
   AST_DESCEND: assert property (take && st_q == ST_KEY &&
      c == `CH_COLON && klen_q != '0 && level_q != `MAX_LEVEL
      |=> level_q == $past(level_q) + 2'd1) else $error("no descent");
   AST_SAME_LEVEL: assert property (push && c == `CH_SEMI
      |=> level_q == $past(level_q) && st_q == ST_SEMI) else $error("level");
   AST_QUERY: assert property (take && key_state && c == `CH_QMARK
      && klen_q != '0 |=> query_q && st_q == ST_QUERY) else $error("no query");
   AST_SETTLE: assert property (sent && freq_cmd
      |=> o_freq_settling [*2]) else $error("settle not started");

   COV_QUERY: cover property (push && cmd_new.query);
   COV_QINT: cover property (take && qint);
   COV_TOP: cover property (take && st_q == ST_SEMI && c == `CH_COLON);
   COV_FULL: cover property (!o_rx_ready ##1 o_rx_ready);
endmodule : gpib_command_parser

/* File: verilog/gpib_parser_cfg.svh */
// Character codes, error codes and timing constants of the command parser
`ifndef GPIB_PARSER_CFG_SVH
`define GPIB_PARSER_CFG_SVH
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_QMARK 8'h3f
`define CH_SPACE 8'h20
`define CH_SQUOTE 8'h27
`define CH_DQUOTE 8'h22
`define CH_NL 8'h0a
`define CH_STAR 8'h2a
`define CH_LOW_A 8'h61
`define CH_LOW_Z 8'h7a
`define CH_UP_A 8'h41
`define CH_UP_Z 8'h5a
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CASE_GAP 8'h20
`define ERR_SYNTAX 16'hff9a
`define ERR_QUERY_INT 16'hfe66
`define KEY_STATUS 32'h2a535442
`define KEY_FREQ 32'h46524551
`define KEY_CHARS 4
`define VALUE_CHARS 8
`define MAX_LEVEL 2'd2
`define CLK_PERIOD_NS 10
`define SETTLE_TIME_NS 150000000
`define SETTLE_CYCLES (`SETTLE_TIME_NS / `CLK_PERIOD_NS)
`endif

/* File: verilog/gpib_parser_pkg.sv */
// Types and character helpers of the command parser
`include "gpib_parser_cfg.svh"
package gpib_parser_pkg;

   typedef struct packed {
      logic [31:0] chars;
      logic [3:0] digit;
      logic has_digit;
   } key_t;

   typedef struct packed {
      key_t [2:0] path;
      logic [1:0] level;
      logic query;
      logic has_value;
      logic quoted;
      logic [63:0] value;
      logic [3:0] value_len;
   } cmd_t;

   typedef enum logic [2:0] {
      ST_KEY = 3'b000,
      ST_SEMI = 3'b001,
      ST_VALUE = 3'b010,
      ST_QUOTE = 3'b011,
      ST_CLOSED = 3'b100,
      ST_QUERY = 3'b101,
      ST_SKIP = 3'b110
   } pstate_t;

   typedef enum logic [1:0] {
      EX_IDLE = 2'b00,
      EX_SEND = 2'b01
   } xstate_t;

   function automatic logic [7:0] fold_case(input logic [7:0] ch);
      if (ch >= `CH_LOW_A && ch <= `CH_LOW_Z)
         return ch - `CASE_GAP;
      return ch;
   endfunction : fold_case

   function automatic logic is_alpha(input logic [7:0] ch);
      logic [7:0] u;
      u = fold_case(ch);
      return u >= `CH_UP_A && u <= `CH_UP_Z;
   endfunction : is_alpha

   function automatic logic is_digit(input logic [7:0] ch);
      return ch >= `CH_ZERO && ch <= `CH_NINE;
   endfunction : is_digit

   // Long names keep four letters, less a trailing vowel, so both forms match
   function automatic key_t close_key(input logic [31:0] chars,
                                      input logic [2:0] klen,
                                      input logic [3:0] digit,
                                      input logic has_digit);
      key_t k;
      logic [7:0] l4;
      k.chars = chars;
      k.digit = digit;
      k.has_digit = has_digit;
      l4 = chars[7:0];
      if (klen > 3'(`KEY_CHARS) && (l4 == 8'h41 || l4 == 8'h45 ||
          l4 == 8'h49 || l4 == 8'h4f || l4 == 8'h55))
         k.chars[7:0] = 8'h00;
      return k;
   endfunction : close_key

endpackage : gpib_parser_pkg
